// >>> include/diag_log_pkg.sv
// diag_log_pkg: constants, codes and carriers for the diagnostic log recorder.
// assumes one 125 MHz ref_clk, an APB master with 32-bit data, and a device core
// that reports task-file writes, errors and finished self-tests as one-cycle events.
// Operation
// R1 - keep records of four most recent errors
// R2 - fifth error overwrites slot one, cyclically
// R3 - never-written error slots read as zeros
// R4 - record: five command snapshots, then error snapshot
// R5 - command snapshot field layout by byte offset
// R6 - command snapshot ends with millisecond timestamp
// R7 - pair low byte newest, high byte previous
// R8 - error snapshot field layout by byte offset
// R9 - pair bytes are read-back with HOB clear/set
// R10 - state byte low nibble encodes device condition
// R11 - lifetime count excludes faulty-command errors
// R12 - lifetime error count saturates at maximum
// R13 - nineteen descriptors, circular reuse from entry one; the code keeps 18 and wraps to entry one after entry 18
// R14 - unwritten descriptors read as zeros
// R15 - self-test sector layout by byte offset
// R16 - self-test revision byte reads 01h
// R17 - descriptor index most recent, zero initially, bounded
// R18 - descriptor field layout, failing address LSB first
// R19 - 28-bit entries also kept in 48-bit log
// R20 - error index most recent, zero initially, 0-4
// R21 - checksum makes all sector bytes sum zero
// R22 - free-running millisecond and hour counters

package diag_log_pkg;

    // time base
    localparam int CLK_PERIOD_NS = 8;
    localparam int MS_NS         = 1_000_000;
    localparam int MS_CYCLES     = MS_NS / CLK_PERIOD_NS;
    localparam int HOUR_MS       = 3_600_000;

    // log geometry
    localparam int ERR_SLOTS      = 4;
    localparam int CMD_SNAPS      = 5;
    localparam int CMD_SNAP_BYTES = 18;
    localparam int ERR_SNAP_BYTES = 34;
    localparam int ERR_REC_BYTES  = CMD_SNAPS * CMD_SNAP_BYTES + ERR_SNAP_BYTES;
    localparam int ST_ENTRIES     = 19;
    localparam int ST_SLOTS       = ST_ENTRIES - 1;
    localparam int ST_DESC_BYTES  = 26;
    localparam int TF_PAIRS       = 5;

    // sector byte offsets
    localparam logic [8:0] OFS_VERSION    = 9'h000;
    localparam logic [8:0] OFS_INDEX      = 9'h002;
    localparam logic [8:0] OFS_FIRST_REC  = 9'h004;
    localparam logic [8:0] OFS_ERR_END    = 9'h1F4;
    localparam logic [8:0] OFS_ERR_CNT    = 9'h1F4;
    localparam logic [8:0] OFS_ERR_CNT_HI = 9'h1F5;
    localparam logic [8:0] OFS_ST_END     = 9'h1F2;
    localparam logic [8:0] OFS_CKSUM_WORD = 9'h1FC;
    localparam logic [8:0] OFS_LAST_SUM   = 9'h1FE;
    localparam logic [8:0] OFS_CKSUM      = 9'h1FF;
    localparam logic [7:0] LOG_REVISION   = 8'h01;
    localparam logic [15:0] ERR_CNT_MAX   = 16'hFFFF;

    // APB map
    localparam logic [11:0] ADDR_ERR_LOG = 12'h000;
    localparam logic [11:0] ADDR_ST_LOG  = 12'h200;
    localparam logic [11:0] ADDR_CTRL    = 12'h400;
    localparam logic [11:0] ADDR_STAT    = 12'h404;
    localparam logic [31:0] CTRL_RESET   = 32'h0000_0001;
    localparam int          CTRL_EN_BIT  = 0;
    localparam int          CTRL_CLR_BIT = 1;

    // task-file register selects
    localparam logic [3:0] TF_DEVCTL     = 4'h0;
    localparam logic [3:0] TF_PAIR_FIRST = 4'h1;
    localparam logic [3:0] TF_DEVICE     = 4'h6;
    localparam logic [3:0] TF_COMMAND    = 4'h7;

    // device condition codes, low nibble of the state byte
    localparam logic [3:0] DEV_UNKNOWN  = 4'h0;
    localparam logic [3:0] DEV_SLEEP    = 4'h1;
    localparam logic [3:0] DEV_STANDBY  = 4'h2;
    localparam logic [3:0] DEV_ACTIVE   = 4'h3;
    localparam logic [3:0] DEV_SELFTEST = 4'h4;

    typedef struct packed {
        logic       wr;
        logic [3:0] sel;
        logic [7:0] data;
    } tf_write_t;

    typedef struct packed {
        logic       valid;
        logic       host_fault;
        logic [7:0] error;
        logic [7:0] status;
        logic [3:0] vendor_state;
        logic [3:0] condition;
    } err_event_t;

    typedef struct packed {
        logic        valid;
        logic        lba28;
        logic [7:0]  number;
        logic [7:0]  status;
        logic [7:0]  checkpoint;
        logic [47:0] lba;
    } st_event_t;

endpackage

// >>> verilog/uptime_counters.sv
// uptime_counters: power-on millisecond and lifetime hour counters.
// assumes ref_clk is free running; counts restart at reset.
`timescale 1ns/1ps
module uptime_counters #(
    parameter int MS_CYCLES = diag_log_pkg::MS_CYCLES,
    parameter int HOUR_MS   = diag_log_pkg::HOUR_MS
) (
    input  wire logic        ref_clk,
    input  wire logic        rst,
    output logic      [31:0] ms_q,
    output logic      [15:0] hours_q
);
    localparam int DIV_W = $clog2(MS_CYCLES);
    localparam int HR_W  = $clog2(HOUR_MS);

    logic [DIV_W-1:0] div_q;
    logic [HR_W-1:0]  hr_ms_q;
    logic             ms_tick;

    assign ms_tick = (div_q == DIV_W'(MS_CYCLES - 1));

    always_ff @(posedge ref_clk) begin
        if (rst || ms_tick) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + DIV_W'(1);
        end
    end

    // ms wraps after about 49 days, as a 4-byte stamp must
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ms_q <= 32'h0000_0000;
        end else if (ms_tick) begin
            ms_q <= ms_q + 32'h0000_0001; // R22
        end
    end

    // hours saturate: the lifetime field has no wrap meaning
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            hr_ms_q <= '0;
            hours_q <= 16'h0000;
        end else if (ms_tick) begin
            if (hr_ms_q == HR_W'(HOUR_MS - 1)) begin
                hr_ms_q <= '0;
                if (hours_q != 16'hFFFF) begin
                    hours_q <= hours_q + 16'h0001; // R22
                end
            end else begin
                hr_ms_q <= hr_ms_q + HR_W'(1);
            end
        end
    end
endmodule

// >>> verilog/diag_log_recorder.sv
// diag_log_recorder: error log and self-test log images behind an APB slave.
// assumes task-file writes and events arrive synchronous to ref_clk as one-cycle
// strobes; the APB master holds each request until pready.
`timescale 1ns/1ps
module diag_log_recorder #(
    parameter int MS_CYCLES = diag_log_pkg::MS_CYCLES,
    parameter int HOUR_MS   = diag_log_pkg::HOUR_MS
) (
    input  wire logic                     ref_clk,
    input  wire logic                     rst,
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [11:0]              paddr,
    input  wire logic [31:0]              pwdata,
    output logic      [31:0]              prdata,
    output logic                          pready,
    output logic                          pslverr,
    input  wire diag_log_pkg::tf_write_t  tf,
    input  wire diag_log_pkg::err_event_t err_ev,
    input  wire diag_log_pkg::st_event_t  st_ev
);
    localparam int CMD_W  = diag_log_pkg::CMD_SNAP_BYTES * 8;
    localparam int ESN_W  = diag_log_pkg::ERR_SNAP_BYTES * 8;
    localparam int REC_W  = diag_log_pkg::ERR_REC_BYTES * 8;
    localparam int DESC_W = diag_log_pkg::ST_DESC_BYTES * 8;
    localparam int NCMD   = diag_log_pkg::CMD_SNAPS;
    localparam int NPAIR  = diag_log_pkg::TF_PAIRS;
    localparam int NERR   = diag_log_pkg::ERR_SLOTS;
    localparam int NST    = diag_log_pkg::ST_SLOTS;

    typedef enum logic [1:0] {BUS_IDLE, BUS_SUM, BUS_FETCH, BUS_DONE} bus_state_t;

    logic [31:0]              ms_now;
    logic [15:0]              hours_now;
    logic [7:0]               cur_q [NPAIR];
    logic [7:0]               prev_q [NPAIR];
    logic [7:0]               devctl_q;
    logic [7:0]               dev_q;
    logic [16*NPAIR-1:0]      pair_bytes;
    logic [CMD_W-1:0]         cmd_snap;
    logic [ESN_W-1:0]         err_snap;
    logic [DESC_W-1:0]        st_desc;
    logic [47:0]              fail_lba;
    logic [NCMD-1:0][CMD_W-1:0] hist_q;
    logic                     en_q;
    logic                     access;
    logic                     wr_done;
    logic                     log_clr;
    logic [REC_W-1:0]         err_mem [NERR];
    logic [NERR-1:0]          err_vld_q;
    logic [2:0]               err_idx_q;
    logic [2:0]               err_base;
    logic [2:0]               err_nxt;
    logic [15:0]              err_cnt_q;
    logic [15:0]              cnt_base;
    logic                     err_log;
    logic [DESC_W-1:0]        st_mem [NST];
    logic [NST-1:0]           st_vld_q;
    logic [4:0]               st_idx_q;
    logic [4:0]               st_base;
    logic [4:0]               st_nxt;
    logic                     st_log;
    bus_state_t               bus_q;
    logic [1:0]               lane_q;
    logic                     rd_st_q;
    logic [8:0]               rd_off_q;
    logic [7:0]               acc_q;
    logic [7:0]               cksum_q;
    logic [7:0]               byte_d;
    logic [8:0]               rel_off;
    logic [1:0]               err_slot;
    logic [6:0]               err_bo;
    logic [4:0]               st_slot;
    logic [4:0]               st_bo;
    logic [31:0]              status_word;

    uptime_counters #(
        .MS_CYCLES (MS_CYCLES),
        .HOUR_MS   (HOUR_MS)
    ) u_uptime (
        .ref_clk (ref_clk),
        .rst     (rst),
        .ms_q    (ms_now),
        .hours_q (hours_now)
    );

    // task-file shadow: each paired register keeps its newest and prior value
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            for (int i = 0; i < NPAIR; i++) begin
                cur_q[i]  <= 8'h00;
                prev_q[i] <= 8'h00;
            end
            devctl_q <= 8'h00;
            dev_q    <= 8'h00;
        end else if (tf.wr) begin
            for (int i = 0; i < NPAIR; i++) begin
                if (tf.sel == 4'(diag_log_pkg::TF_PAIR_FIRST + i)) begin
                    prev_q[i] <= cur_q[i]; // R7
                    cur_q[i]  <= tf.data;
                end
            end
            if (tf.sel == diag_log_pkg::TF_DEVCTL) begin
                devctl_q <= tf.data;
            end
            if (tf.sel == diag_log_pkg::TF_DEVICE) begin
                dev_q <= tf.data;
            end
        end
    end

    always_comb begin
        pair_bytes = '0;
        for (int i = 0; i < NPAIR; i++) begin
            pair_bytes[16*i +: 16] = {prev_q[i], cur_q[i]};
        end
    end

    // byte 0 sits in the low bits of every image
    assign cmd_snap = {ms_now, 8'h00, tf.data, dev_q, pair_bytes, devctl_q}; // R5 R6
    // shadow current/prior equal what HOB=0/HOB=1 reads return
    assign err_snap = {hours_now, err_ev.vendor_state, err_ev.condition, 152'h0,
                       err_ev.status, dev_q, pair_bytes[16*NPAIR-1:16],
                       err_ev.error, 8'h00}; // R8 R9 R10
    assign fail_lba = st_ev.lba28 ? {20'h0_0000, st_ev.lba[27:0]} : st_ev.lba; // R19
    assign st_desc  = {120'h0, fail_lba, st_ev.checkpoint, hours_now,
                       st_ev.status, st_ev.number}; // R18

    // five most recent commands, oldest in entry 0
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            hist_q <= '0;
        end else if (tf.wr && tf.sel == diag_log_pkg::TF_COMMAND) begin
            hist_q <= {cmd_snap, hist_q[NCMD-1:1]};
        end
    end

    // control register
    assign access  = psel && penable;
    assign wr_done = access && pwrite && bus_q == BUS_DONE;
    assign log_clr = wr_done && paddr == diag_log_pkg::ADDR_CTRL
                     && pwdata[diag_log_pkg::CTRL_CLR_BIT];

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            en_q <= diag_log_pkg::CTRL_RESET[diag_log_pkg::CTRL_EN_BIT];
        end else if (wr_done && paddr == diag_log_pkg::ADDR_CTRL) begin
            en_q <= pwdata[diag_log_pkg::CTRL_EN_BIT];
        end
    end

    // error log; an event in the clearing cycle is still logged
    assign err_log  = en_q && err_ev.valid;
    assign err_base = log_clr ? 3'h0 : err_idx_q;
    assign err_nxt  = (err_base == 3'(NERR)) ? 3'h1 : 3'(err_base + 3'h1); // R2
    assign cnt_base = log_clr ? 16'h0000 : err_cnt_q;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            err_vld_q <= '0;
            err_idx_q <= 3'h0;
            err_cnt_q <= 16'h0000;
        end else begin
            if (log_clr) begin
                err_vld_q <= '0;
                err_idx_q <= 3'h0;
                err_cnt_q <= 16'h0000;
            end
            if (err_log) begin
                err_idx_q <= err_nxt; // R20
                err_vld_q[2'(err_nxt - 3'h1)] <= 1'b1; // R1
                if (!err_ev.host_fault && cnt_base != diag_log_pkg::ERR_CNT_MAX) begin
                    err_cnt_q <= cnt_base + 16'h0001; // R11 R12
                end
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (err_log) begin
            err_mem[2'(err_nxt - 3'h1)] <= {err_snap, hist_q}; // R1 R4
        end
    end

    // self-test log; entry 19 is laid out but never reached by the wrap
    assign st_log  = en_q && st_ev.valid;
    assign st_base = log_clr ? 5'h00 : st_idx_q;
    assign st_nxt  = (st_base == 5'(NST)) ? 5'h01 : 5'(st_base + 5'h01); // R13

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            st_vld_q <= '0;
            st_idx_q <= 5'h00;
        end else begin
            if (log_clr) begin
                st_vld_q <= '0;
                st_idx_q <= 5'h00;
            end
            if (st_log) begin
                st_idx_q <= st_nxt; // R17
                st_vld_q[5'(st_nxt - 5'h01)] <= 1'b1; // R13
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (st_log) begin
            st_mem[5'(st_nxt - 5'h01)] <= st_desc; // R13
        end
    end

    // one byte of either sector image at rd_off_q
    always_comb begin
        rel_off  = rd_off_q - diag_log_pkg::OFS_FIRST_REC;
        err_slot = 2'(rel_off / diag_log_pkg::ERR_REC_BYTES);
        err_bo   = 7'(rel_off % diag_log_pkg::ERR_REC_BYTES);
        st_slot  = 5'(rel_off / diag_log_pkg::ST_DESC_BYTES);
        st_bo    = 5'(rel_off % diag_log_pkg::ST_DESC_BYTES);
        byte_d   = 8'h00;
        if (rd_off_q == diag_log_pkg::OFS_VERSION) begin
            byte_d = diag_log_pkg::LOG_REVISION; // R16
        end else if (rd_off_q == diag_log_pkg::OFS_INDEX) begin
            byte_d = rd_st_q ? {3'h0, st_idx_q} : {5'h00, err_idx_q}; // R17 R20
        end else if (rd_off_q == diag_log_pkg::OFS_CKSUM) begin
            byte_d = cksum_q; // R21
        end else if (!rd_st_q) begin
            if (rd_off_q >= diag_log_pkg::OFS_FIRST_REC
                && rd_off_q < diag_log_pkg::OFS_ERR_END) begin
                if (err_vld_q[err_slot]) begin
                    byte_d = err_mem[err_slot][8*err_bo +: 8]; // R3 R4
                end
            end else if (rd_off_q == diag_log_pkg::OFS_ERR_CNT) begin
                byte_d = err_cnt_q[7:0];
            end else if (rd_off_q == diag_log_pkg::OFS_ERR_CNT_HI) begin
                byte_d = err_cnt_q[15:8];
            end
        end else if (rd_off_q >= diag_log_pkg::OFS_FIRST_REC
                     && rd_off_q < diag_log_pkg::OFS_ST_END && st_slot < 5'(NST)) begin
            if (st_vld_q[st_slot]) begin
                byte_d = st_mem[st_slot][8*st_bo +: 8]; // R14 R15
            end
        end
    end

    assign status_word = {err_cnt_q, 3'h0, st_idx_q, 5'h00, err_idx_q};

    // APB slave: log words are gathered a byte per cycle; the checksum word
    // first walks all 511 bytes, a slow read traded for no adder tree
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            bus_q    <= BUS_IDLE;
            pready   <= 1'b0;
            pslverr  <= 1'b0;
            prdata   <= 32'h0000_0000;
            lane_q   <= 2'h0;
            rd_st_q  <= 1'b0;
            rd_off_q <= 9'h000;
            acc_q    <= 8'h00;
            cksum_q  <= 8'h00;
        end else begin
            unique case (bus_q)
                BUS_IDLE: begin
                    pready  <= 1'b0;
                    pslverr <= 1'b0;
                    if (access && !pwrite && paddr < diag_log_pkg::ADDR_CTRL) begin
                        rd_st_q <= paddr[9];
                        lane_q  <= 2'h0;
                        if ({paddr[8:2], 2'h0} == diag_log_pkg::OFS_CKSUM_WORD) begin
                            rd_off_q <= diag_log_pkg::OFS_VERSION;
                            acc_q    <= 8'h00;
                            bus_q    <= BUS_SUM;
                        end else begin
                            rd_off_q <= {paddr[8:2], 2'h0};
                            bus_q    <= BUS_FETCH;
                        end
                    end else if (access) begin
                        bus_q   <= BUS_DONE;
                        pready  <= 1'b1;
                        pslverr <= !(paddr == diag_log_pkg::ADDR_CTRL
                                     || (paddr == diag_log_pkg::ADDR_STAT && !pwrite));
                        if (paddr == diag_log_pkg::ADDR_CTRL) begin
                            prdata <= {31'h0000_0000, en_q};
                        end else if (paddr == diag_log_pkg::ADDR_STAT) begin
                            prdata <= status_word;
                        end else begin
                            prdata <= 32'h0000_0000;
                        end
                    end
                end
                BUS_SUM: begin
                    acc_q    <= acc_q + byte_d;
                    rd_off_q <= rd_off_q + 9'h001;
                    if (rd_off_q == diag_log_pkg::OFS_LAST_SUM) begin
                        cksum_q  <= 8'h00 - (acc_q + byte_d); // R21
                        rd_off_q <= diag_log_pkg::OFS_CKSUM_WORD;
                        bus_q    <= BUS_FETCH;
                    end
                end
                BUS_FETCH: begin
                    prdata   <= {byte_d, prdata[31:8]};
                    rd_off_q <= rd_off_q + 9'h001;
                    lane_q   <= lane_q + 2'h1;
                    if (lane_q == 2'h3) begin
                        bus_q  <= BUS_DONE;
                        pready <= 1'b1;
                    end
                end
                BUS_DONE: begin
                    pready  <= 1'b0;
                    pslverr <= 1'b0;
                    bus_q   <= BUS_IDLE;
                end
            endcase
        end
    end

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    chk_err_idx_range: assert property (err_idx_q <= 3'(NERR)) // R20
        else $error("error log index out of range");

    chk_st_idx_range: assert property (st_idx_q <= 5'(NST)) // R17
        else $error("self-test index out of range");

    chk_err_wrap: assert property ( // R2
        (err_log && !log_clr && err_idx_q == 3'(NERR)) |=> err_idx_q == 3'h1)
        else $error("error log did not wrap to slot one");

    chk_err_slot_set: assert property ( // R1
        err_log |=> (err_idx_q == $past(err_nxt)) && err_vld_q[2'(err_idx_q - 3'h1)])
        else $error("logged error slot not marked");

    chk_cnt_fault: assert property ( // R11
        (err_log && err_ev.host_fault && !log_clr) |=> $stable(err_cnt_q))
        else $error("faulty command changed error count");

    chk_cnt_inc: assert property ( // R11
        (err_log && !err_ev.host_fault && !log_clr
         && err_cnt_q != diag_log_pkg::ERR_CNT_MAX)
        |=> err_cnt_q == $past(err_cnt_q) + 16'h0001)
        else $error("device error not counted");

    chk_cnt_sat: assert property ( // R12
        (err_cnt_q == diag_log_pkg::ERR_CNT_MAX && !log_clr)
        |=> err_cnt_q == diag_log_pkg::ERR_CNT_MAX)
        else $error("error count left saturation");

    chk_st_wrap: assert property ( // R13
        (st_log && !log_clr && st_idx_q == 5'(NST)) |=> st_idx_q == 5'h01)
        else $error("self-test log did not wrap to entry one");

    chk_cksum_zero: assert property ( // R21
        (bus_q == BUS_SUM && rd_off_q == diag_log_pkg::OFS_LAST_SUM)
        |=> 8'(cksum_q + $past(acc_q) + $past(byte_d)) == 8'h00)
        else $error("checksum does not zero the sector sum");

    chk_ready_pulse: assert property (pready |=> !pready)
        else $error("pready held longer than one cycle");
endmodule

// >>> testbench/core_model.sv
// core_model: device core stand-in reporting task-file writes, errors, self-tests.
// assumes the bench calls its tasks from one process; strobes change after edges.
`timescale 1ns/1ps
module core_model (
    input  wire logic                ref_clk,
    output diag_log_pkg::tf_write_t  tf,
    output diag_log_pkg::err_event_t err_ev,
    output diag_log_pkg::st_event_t  st_ev
);
    initial begin
        tf     = '0;
        err_ev = '0;
        st_ev  = '0;
    end

    task automatic pulse_tf(input logic [3:0] sel, input logic [7:0] d);
        @(posedge ref_clk);
        tf <= '{1'b1, sel, d};
        @(posedge ref_clk);
        tf <= '0;
    endtask

    // n > 1 holds valid high: one error per cycle, the fastest way to saturate
    task automatic report_err(input logic hf, input logic [3:0] cond, input int n);
        @(posedge ref_clk);
        err_ev <= '{1'b1, hf, 8'h04, 8'h51, 4'h0, cond};
        repeat (n) @(posedge ref_clk);
        err_ev <= '0;
    endtask

    task automatic selftest(input logic [7:0] num, input logic l28, input logic [47:0] lba);
        @(posedge ref_clk);
        st_ev <= '{1'b1, l28, num, 8'h21, 8'h0C, lba};
        @(posedge ref_clk);
        st_ev <= '0;
    endtask
endmodule

// >>> testbench/tb_error_and_selftest_log_recorder.sv
// tb_error_and_selftest_log_recorder: APB reads of both log images after events.
// assumes shortened time base (MS_CYCLES 10, HOUR_MS 5) and the core_model source.
`timescale 1ns/1ps
module tb_error_and_selftest_log_recorder;
    logic                     ref_clk   = 1'b0;
    logic                     rst       = 1'b1;
    logic                     psel      = 1'b0;
    logic                     penable   = 1'b0;
    logic                     pwrite    = 1'b0;
    logic [11:0]              paddr     = '0;
    logic [31:0]              pwdata    = '0;
    logic [31:0]              prdata;
    logic                     pready;
    logic                     pslverr;
    logic [31:0]              rd;
    logic                     se;
    int                       n_errors  = 0;
    int                       cmp_count = 0;
    int                       cnt;
    int                       idx;
    int                       a;
    diag_log_pkg::tf_write_t  tf;
    diag_log_pkg::err_event_t err_ev;
    diag_log_pkg::st_event_t  st_ev;

    always #4 ref_clk = ~ref_clk;

    core_model u_core (.ref_clk(ref_clk), .tf(tf), .err_ev(err_ev), .st_ev(st_ev));

    diag_log_recorder #(.MS_CYCLES(10), .HOUR_MS(5)) u_dut (
        .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .tf(tf), .err_ev(err_ev), .st_ev(st_ev));

    task automatic summarize();
        $display("checks %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // pready is read at the rising edge, before that edge's own updates land
    task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] d);
        int k;
        @(posedge ref_clk);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= ad;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge ref_clk);
            k++;
        end while (pready !== 1'b1 && k < 1000);
        rd = prdata;
        se = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            n_errors++;
            summarize();
        end
    endtask

    task automatic rchk(input logic [11:0] ad, input logic [31:0] m, input logic [31:0] e);
        apb(1'b0, ad, 32'h0);
        check(rd & m, e);
    endtask

    initial begin
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        rchk(12'h404, 32'hFFFF_FFFF, 32'h0);
        rchk(12'h200, 32'hFFFF_FFFF, 32'h0000_0001);
        rchk(12'h004, 32'hFFFF_FFFF, 32'h0);
        rchk(12'h204, 32'hFFFF_FFFF, 32'h0);
        rchk(12'h3FC, 32'hFFFF_FFFF, 32'hFF00_0000);
        $display("test reset_image done");

        u_core.pulse_tf(diag_log_pkg::TF_PAIR_FIRST, 8'h11);
        u_core.pulse_tf(diag_log_pkg::TF_PAIR_FIRST, 8'h22);
        u_core.pulse_tf(diag_log_pkg::TF_COMMAND, 8'hEC);
        u_core.report_err(1'b0, diag_log_pkg::DEV_ACTIVE, 1);
        rchk(12'h04C, 32'hFFFF_FFFF, 32'h0011_2200);
        rchk(12'h058, 32'h0000_00FF, 32'h0000_00EC);
        rchk(12'h05C, 32'hFF00_0000, 32'h0400_0000);
        for (int k = 1; k < 6; k++) begin
            u_core.report_err(k == 4, 4'(k % 5), 1);
            cnt = (k >= 4) ? k : k + 1;
            idx = (k % 4) + 1;
            rchk(12'h404, 32'hFFFF_0007, {16'(cnt), 13'h0, 3'(idx)});
            a = 4 + (idx - 1) * 124 + 'h79;
            rchk(12'(a & ~3), 32'hFF << (8 * (a % 4)), 32'(k % 5) << (8 * (a % 4)));
        end
        $display("test error_log done");

        for (int n = 1; n <= 19; n++) begin
            u_core.selftest(8'(n), n == 19, 48'hA5A4_F123_4567);
            rchk(12'h404, 32'h0000_1F00, {19'h0, 5'((n - 1) % 18 + 1), 8'h0});
        end
        rchk(12'h204, 32'h0000_FFFF, 32'h0000_2113);
        rchk(12'h208, 32'hFFFF_FFFF, 32'h2345_670C);
        rchk(12'h20C, 32'hFFFF_FFFF, 32'h0000_0001);
        rchk(12'h3C4, 32'hFFFF_FFFF, 32'hA4F1_2345);
        rchk(12'h3D8, 32'hFFFF_FFFF, 32'h0);
        $display("test selftest_log done");

        apb(1'b1, 12'h004, 32'hFFFF_FFFF);
        check({31'h0, se}, 32'h1);
        apb(1'b0, 12'h408, 32'h0);
        check({31'h0, se}, 32'h1);
        u_core.report_err(1'b0, diag_log_pkg::DEV_ACTIVE, 65540);
        rchk(12'h404, 32'hFFFF_0000, 32'hFFFF_0000);
        apb(1'b1, 12'h400, 32'h0000_0003);
        rchk(12'h404, 32'hFFFF_FFFF, 32'h0);
        rchk(12'h004, 32'hFFFF_FFFF, 32'h0);
        // logging disabled: events must leave both logs empty
        apb(1'b1, 12'h400, 32'h0000_0000);
        u_core.report_err(1'b0, diag_log_pkg::DEV_ACTIVE, 1);
        u_core.selftest(8'h01, 1'b0, 48'h0);
        rchk(12'h404, 32'hFFFF_FFFF, 32'h0);
        rchk(12'h204, 32'hFFFF_FFFF, 32'h0);
        $display("test bus_and_count done");
        summarize();
    end
endmodule
